// file: inc/spare_bit_pkg.sv
// constants and types shared by the spare-bit buffer block
package spare_bit_pkg;
	// register map: page and offset
	localparam logic [7:0] PAGE_CTRL = 8'h01;
	localparam logic [7:0] PAGE_TX_SPARE = 8'h0E;
	localparam logic [7:0] PAGE_RX_SPARE = 8'h0F;
	localparam logic [4:0] OFF_SPARE_FIRST = 5'h10;
	localparam logic [4:0] OFF_SPARE_LAST = 5'h14;
	localparam logic [4:0] OFF_SPARE_CTRL = 5'h17;
	// field position of the transmit enable in the control register
	localparam int SPARE_TX_EN_BIT = 0;
	// reset values
	localparam logic [7:0] SPARE_BYTE_RST = 8'h00;
	localparam logic SPARE_TX_EN_RST = 1'b0;
	// counts
	localparam int SPARE_BYTES = 5;
	localparam int SPARE_FIRST_POS = 4;
	localparam logic [2:0] SPARE_LAST_SLOT = 3'h7;
	// host access kind
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_READ = 2'b01,
		ACC_WRITE = 2'b10
	} acc_kind_t;
endpackage : spare_bit_pkg

// file: src/spare_bit_slot_counter.sv
// counts odd frames into the eight-frame sequence of spare bits
`timescale 1ns/1ps
module spare_bit_slot_counter
	import spare_bit_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// frame timing
	input wire logic odd_frame_i,
	input wire logic mf_start_i,
	input wire logic crc4_mf_i,
	// sequence position
	output logic [2:0] slot_o,
	output logic last_o
);
	typedef struct packed {
		logic [2:0] slot;
	} cnt_state_t;
	cnt_state_t s_q, s_d;

	// advance per odd frame; multiframe start pins slot 0 under crc-4
	always_comb begin
		s_d = s_q;
		if (odd_frame_i) begin
			if (crc4_mf_i && mf_start_i) begin
				s_d.slot = 3'h1;
			end else begin
				s_d.slot = s_q.slot + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// slot used by the current odd frame
	assign slot_o = (crc4_mf_i && mf_start_i) ? 3'h0 : s_q.slot;
	assign last_o = (slot_o == SPARE_LAST_SLOT);
endmodule : spare_bit_slot_counter

// file: src/e1_spare_bit_buffers.sv
// E1 spare bit transmit and receive buffers with paged host access
`timescale 1ns/1ps
// Functional notes
// - five host-writable transmit bytes at page 0EH offsets 10H to 14H
// - transmit bytes inserted only while the transmit enable bit is one
// - with crc-4 alignment byte n goes to bit n+4 of frames 1..15 odd
// - without alignment bits go into eight consecutive odd frames
// - byte index 0..4 maps to spare-bit positions four through eight
// - five host-readable receive bytes at page 0FH offsets 10H to 14H
// - receive byte n captures bit n+4 of the odd frame sequence
module e1_spare_bit_buffers
	import spare_bit_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// host register port
	input wire logic [7:0] page_i,
	input wire logic [4:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// framer timing
	input wire logic ts0_odd_i,
	input wire logic mf_start_i,
	input wire logic crc4_mf_i,
	// receive spare bits of the current odd frame, positions 4..8
	input wire logic [4:0] rx_bits_i,
	// transmit spare bits for the current odd frame
	output logic [4:0] tx_bits_o,
	output logic tx_insert_o,
	output logic rx_spare_bit_frame15_o
);
	typedef struct packed {
		logic [SPARE_BYTES-1:0][7:0] tx_buf;
		logic [SPARE_BYTES-1:0][7:0] rx_shift;
		logic [SPARE_BYTES-1:0][7:0] rx_buf;
		logic spare_bit_tx_enable;
		logic [7:0] rdata;
		logic rvalid;
		logic [4:0] tx_bits;
		logic tx_insert;
		logic frame15;
	} state_t;
	state_t s_q, s_d;

	logic [2:0] slot;
	logic last;
	acc_kind_t acc;

	// true when the offset falls in the spare byte range
	function automatic logic in_spare(input logic [4:0] a);
		return (a >= OFF_SPARE_FIRST) && (a <= OFF_SPARE_LAST);
	endfunction : in_spare

	function automatic logic [2:0] spare_idx(input logic [4:0] a);
		return 3'(a - OFF_SPARE_FIRST);
	endfunction : spare_idx

	spare_bit_slot_counter u_slot (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.odd_frame_i(ts0_odd_i),
		.mf_start_i(mf_start_i),
		.crc4_mf_i(crc4_mf_i),
		.slot_o(slot),
		.last_o(last)
	);

	assign acc = wr_i ? ACC_WRITE : (rd_i ? ACC_READ : ACC_IDLE);

	// next state for host access and frame processing
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.tx_insert = 1'b0;
		unique case (acc)
			ACC_WRITE: begin
				if (page_i == PAGE_TX_SPARE && in_spare(addr_i)) begin
					s_d.tx_buf[spare_idx(addr_i)] = wdata_i;
				end
				if (page_i == PAGE_CTRL && addr_i == OFF_SPARE_CTRL) begin
					s_d.spare_bit_tx_enable = wdata_i[SPARE_TX_EN_BIT];
				end
			end
			ACC_READ: begin
				s_d.rvalid = 1'b1;
				s_d.rdata = 8'h00;
				if (page_i == PAGE_TX_SPARE && in_spare(addr_i)) begin
					s_d.rdata = s_q.tx_buf[spare_idx(addr_i)];
				end
				if (page_i == PAGE_RX_SPARE && in_spare(addr_i)) begin
					s_d.rdata = s_q.rx_buf[spare_idx(addr_i)];
				end
				if (page_i == PAGE_CTRL && addr_i == OFF_SPARE_CTRL) begin
					s_d.rdata = {7'h00, s_q.spare_bit_tx_enable};
				end
			end
			ACC_IDLE: begin
			end
			default: begin
			end
		endcase
		if (ts0_odd_i) begin
			for (int n = 0; n < SPARE_BYTES; n++) begin
				// slot 0 takes msb, slot 7 the lsb
				s_d.tx_bits[n] = s_q.tx_buf[n][SPARE_LAST_SLOT - slot];
				s_d.rx_shift[n] = {s_q.rx_shift[n][6:0], rx_bits_i[n]};
			end
			s_d.tx_insert = s_q.spare_bit_tx_enable;
			if (last) begin
				for (int n = 0; n < SPARE_BYTES; n++) begin
					s_d.rx_buf[n] = {s_q.rx_shift[n][6:0], rx_bits_i[n]};
				end
				s_d.frame15 = rx_bits_i[0];
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign rvalid_o = s_q.rvalid;
	assign tx_bits_o = s_q.tx_bits;
	assign tx_insert_o = s_q.tx_insert;
	assign rx_spare_bit_frame15_o = s_q.frame15;
endmodule : e1_spare_bit_buffers

// file: verif/spare_bit_checker.sv
// port assertions for the spare-bit buffers
`timescale 1ns/1ps
module spare_bit_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// host register port
	input wire logic [7:0] page_i,
	input wire logic [4:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	// framer timing and spare bits
	input wire logic ts0_odd_i,
	input wire logic [4:0] tx_bits_o,
	input wire logic tx_insert_o,
	input wire logic rx_spare_bit_frame15_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// host answers and frame side timing
	chk_read_answer: assert property (rd_i&&!wr_i |=> rvalid_o) else $error("no answer");
	chk_answer_cause: assert property (rvalid_o |-> $past(rd_i&&!wr_i)) else $error("stray answer");
	chk_rdata_hold: assert property (!$past(rd_i) |-> $stable(rdata_o)) else $error("rdata moved");
	chk_unmapped_zero: assert property (rd_i&&!wr_i&&page_i==8'h00 |=> rdata_o==8'h00) else $error("unmapped");
	chk_ctrl_bits: assert property (rd_i&&!wr_i&&page_i==8'h01&&addr_i==5'h17 |=> rdata_o[7:1]==7'h00)
		else $error("ctrl bits");
	chk_insert_cause: assert property (tx_insert_o |-> $past(ts0_odd_i)) else $error("insert");
	chk_bits_hold: assert property (!$past(ts0_odd_i) |-> $stable(tx_bits_o)) else $error("tx bits");
	chk_rx_update: assert property ($changed(rx_spare_bit_frame15_o) |-> $past(ts0_odd_i)||$past(ts0_odd_i,2))
		else $error("rx update");
endmodule : spare_bit_checker
bind e1_spare_bit_buffers spare_bit_checker chk_u(.*);

// file: verif/e1_far_end.sv
// remote terminal: odd-frame timing and received spare bits
`timescale 1ns/1ps
module e1_far_end (
	// clock
	input wire logic clk_i,
	// bits coming from the block
	input wire logic tx_insert_i,
	input wire logic [4:0] tx_bits_i,
	// frame timing and bits going to the block
	output logic ts0_odd_o,
	output logic mf_start_o,
	output logic [4:0] rx_bits_o
);
	initial {ts0_odd_o,mf_start_o,rx_bits_o}=7'h00;
	// one odd frame, bits inverted once the pulse is gone
	task automatic frame(input logic mf,input logic [4:0] b,output logic [5:0] got);
		@(negedge clk_i) {ts0_odd_o,mf_start_o,rx_bits_o}<={1'b1,mf,b};
		@(negedge clk_i) {ts0_odd_o,mf_start_o,rx_bits_o}<={2'b00,~b};
		got={tx_insert_i,tx_bits_i};
		repeat (2) @(negedge clk_i);
	endtask : frame
endmodule : e1_far_end

// file: verif/e1_spare_bit_buffers_bench.sv
// self-checking bench for the spare-bit buffers
`timescale 1ns/1ps
`define CHK(a,e) begin tests_run++; if ((a)!==(e)) begin failures++; $display("MISMATCH t=%0t %h %h",$time,a,e); end end
module e1_spare_bit_buffers_bench;
	import spare_bit_pkg::*;
	logic clk_i=0,srst_i=1,rd_i=0,wr_i=0,crc4_mf_i=0,ts0,mf,rvalid_o,tx_insert_o,f15;
	logic [7:0] page_i=0,wdata_i=0,rdata_o;
	logic [4:0] addr_i=0,rxb,tx_bits_o;
	int failures=0,tests_run=0;
	always #25 clk_i=~clk_i;
	e1_spare_bit_buffers dut_u(.clk_i,.srst_i,.page_i,.addr_i,.rd_i,.wr_i,.wdata_i,.rdata_o,.rvalid_o,
		.ts0_odd_i(ts0),.mf_start_i(mf),.crc4_mf_i,.rx_bits_i(rxb),.tx_bits_o,.tx_insert_o,.rx_spare_bit_frame15_o(f15));
	e1_far_end far_u(.clk_i,.tx_insert_i(tx_insert_o),.tx_bits_i(tx_bits_o),.ts0_odd_o(ts0),.mf_start_o(mf),.rx_bits_o(rxb));
	// host write and checked read
	task automatic wr(input logic [7:0] p,input logic [4:0] a,input logic [7:0] d);
		@(negedge clk_i) {page_i,addr_i,wdata_i,wr_i}<={p,a,d,1'b1};
		@(negedge clk_i) wr_i<=0;
	endtask : wr
	task automatic rd(input logic [7:0] p,input logic [4:0] a,input logic [7:0] e);
		@(negedge clk_i) {page_i,addr_i,rd_i}<={p,a,1'b1};
		@(negedge clk_i) rd_i<=0;
		`CHK({rvalid_o,rdata_o},{1'b1,e})
	endtask : rd
	// eight odd frames: tx bits msb first, rx bytes captured
	task automatic run8(input logic crc,en);
		logic [7:0] b;
		logic [4:0] e;
		logic [5:0] g;
		crc4_mf_i<=crc;
		for (int f=0;f<8;f++) begin
			for (int k=0;k<5;k++) begin
				b=8'(8'h96+k);
				e[k]=b[7-f];
			end
			far_u.frame(crc&&f==0,~e,g);
			`CHK(g&{1'b1,{5{en}}},{en,e&{5{en}}})
		end
		for (int k=0;k<5;k++) rd(PAGE_RX_SPARE,5'(OFF_SPARE_FIRST+k),8'(~(8'h96+k)));
		`CHK(f15,1'b1)
	endtask : run8
	// register defaults, read-only receive page, write and readback
	task automatic reg_access;
		rd(PAGE_TX_SPARE,OFF_SPARE_LAST,SPARE_BYTE_RST);
		wr(PAGE_RX_SPARE,OFF_SPARE_FIRST,8'hFF);
		rd(PAGE_RX_SPARE,OFF_SPARE_FIRST,8'h00);
		for (int k=0;k<5;k++) wr(PAGE_TX_SPARE,5'(OFF_SPARE_FIRST+k),8'(8'h96+k));
		rd(PAGE_TX_SPARE,OFF_SPARE_LAST,8'h9A);
		rd(8'h00,OFF_SPARE_FIRST,8'h00);
		wr(PAGE_CTRL,OFF_SPARE_CTRL,8'hFF);
		rd(PAGE_CTRL,OFF_SPARE_CTRL,8'h01);
	endtask : reg_access
	// slot count knocked off zero, multiframe start must pull it back
	task automatic crc_resync;
		logic [5:0] g;
		far_u.frame(1'b0,5'h00,g);
		run8(1,1);
	endtask : crc_resync
	// reset in mid-run clears buffers, enable and frame 15 bit
	task automatic reset_mid;
		wr(PAGE_CTRL,OFF_SPARE_CTRL,8'hFF);
		@(negedge clk_i) srst_i<=1;
		repeat (3) @(negedge clk_i);
		srst_i<=0;
		rd(PAGE_CTRL,OFF_SPARE_CTRL,8'h00);
		rd(PAGE_TX_SPARE,OFF_SPARE_FIRST,SPARE_BYTE_RST);
		rd(PAGE_RX_SPARE,OFF_SPARE_LAST,SPARE_BYTE_RST);
		`CHK(f15,1'b0)
	endtask : reset_mid
	task automatic summarize;
		$display("tests_run=%0d failures=%0d",tests_run,failures);
		if (failures==0&&tests_run>0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// main sequence
	initial begin
		repeat (6) @(negedge clk_i);
		srst_i<=0;
		reg_access();
		crc_resync();
		run8(0,1);
		wr(PAGE_CTRL,OFF_SPARE_CTRL,8'h00);
		run8(1,0);
		reset_mid();
		summarize();
	end
	// watchdog
	initial begin
		#100000;
		failures++;
		summarize();
	end
endmodule : e1_spare_bit_buffers_bench
